//--- core/osc_pkg.sv
package osc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] REFQ_LOW_OFS = 8'h12; // Reference word low byte
    localparam logic [7:0] CTRL_OFS = 8'h87; // Reset, freeze, reload
    localparam logic [7:0] LOOP_OFS = 8'h89; // Synthesis loop freeze

    // Control register bit positions
    localparam int CTRL_RST_BIT = 7; // Internal reset
    localparam int CTRL_NF_BIT = 6; // New frequency handshake
    localparam int CTRL_FRZM_BIT = 5; // Multiplier word freeze
    localparam int CTRL_FRZC_BIT = 4; // Converter freeze
    localparam int CTRL_RECALL_BIT = 0; // Reload from nonvolatile memory
    localparam int LOOP_FRZ_BIT = 4; // Loop freeze in its own register

    // Reset values (undefined middle control bits are given zero)
    localparam logic [7:0] REFQ_LOW_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic LOOP_RST = 1'b0;

    // Nonvolatile memory image, arbitrary neutral defaults
    localparam int NVM_WORDS = 2;
    localparam logic [7:0] NVM_REFQ_INIT = 8'h3c;
    localparam logic [7:0] NVM_LOOP_INIT = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000; // ref_clk, 200 MHz
    localparam int INT_RST_TIME_NS = 100; // Internal reset duration
    localparam int APPLY_TIME_NS = 50; // New frequency settle time
    localparam int INT_RST_CYCLES =
        (INT_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int APPLY_CYCLES =
        (APPLY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CONV_W = 8; // Converter output word width

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_REG, L_WDATA, L_ACK_W, L_ACK_H,
        L_TX, L_MACK_W, L_MACK, L_TX_LOAD
    } osc_lstate_t;

    // Request handed from the serial side to the register side
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } osc_cmd_t;

    // Serial side state
    typedef struct packed {
        osc_lstate_t st;
        osc_lstate_t after;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic oe;
        logic req_tgl;
        osc_cmd_t cmd;
        logic [7:0] rdata;
    } osc_link_t;

    // Register side state
    typedef struct packed {
        logic [7:0] refq;
        logic [7:0] ctrl;
        logic loop_frz;
        logic [4:0] rst_cnt;
        logic [4:0] nf_cnt;
        logic [1:0] rc;
        logic [7:0] freq_word;
        logic [CONV_W-1:0] conv_word;
        logic clk_oe;
        logic ack_tgl;
        logic [7:0] rdata;
    } osc_core_t;

endpackage : osc_pkg

//--- core/osc_nvm.sv
`timescale 1ns/1ps
module osc_nvm
    import osc_pkg::*;
#(
    parameter int WORDS = NVM_WORDS,
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic [$clog2(WORDS)-1:0] addr,
    output logic [W-1:0] rdata
);

    // ****************************************************************
    // Fixed contents, read through a register
    // ****************************************************************
    logic [W-1:0] mem [WORDS]; // Factory image
    logic [W-1:0] rdata_nxt; // Word looked up this cycle

    always_comb begin
        mem[0] = W'(NVM_REFQ_INIT);
        mem[1] = W'(NVM_LOOP_INIT);
        rdata_nxt = mem[addr];
    end

    // Registered read port
    always_ff @(posedge ref_clk) begin
        rdata <= rdata_nxt;
    end

endmodule : osc_nvm

//--- core/osc_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Low reference byte stored, drives frequency word
// - Bit 7 resets logic, clock output tristated
// - Reset bit clears itself when done
// - Internal reset aborts serial state machine
// - New frequency bit self-clears once applied
// - Multiplier freeze holds frequency word
// - Converter freeze holds converter word
// - Reload copies memory, then clears itself
// - Reload leaves serial state machine running
// - Loop freeze bit holds synthesis loop
// - Control register resets to zero
module osc_ctrl
    import osc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h55 // Arbitrary bus address
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [CONV_W-1:0] conv_word_i,
    output logic [7:0] freq_word,
    output logic [CONV_W-1:0] conv_word,
    output logic loop_frozen,
    output logic clk_out_oe
);

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    // Register read image; unused control bits read zero
    function automatic logic [7:0] read_img(osc_core_t c, logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            REFQ_LOW_OFS: v = c.refq;
            CTRL_OFS: v = c.ctrl & 8'hf1;
            LOOP_OFS: v[LOOP_FRZ_BIT] = c.loop_frz;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_img

    // Fresh request for the register side
    function automatic osc_cmd_t mk_cmd(logic w, logic [7:0] a,
                                        logic [7:0] d);
        osc_cmd_t c;
        c.wr = w;
        c.addr = a;
        c.data = d;
        return c;
    endfunction : mk_cmd

    // ****************************************************************
    // Link side synchronisers
    // ****************************************************************
    osc_link_t lr, ln; // Serial state and its next value
    osc_core_t cr, cn; // Register state and its next value
    logic scl_m, scl_s, scl_p; // Clock pin, two stages plus history
    logic sda_m, sda_s, sda_p; // Data pin, two stages plus history
    logic ack_m, ack_s, ack_p; // Answer toggle from register side
    logic abt_m, abt_s; // Internal reset level, aborts the link
    logic lrst_m, lrst_s; // Reset carried into link domain
    logic sda_o_r; // Open drain output level

    // Pins and register side signals pass two flops before use
    always_ff @(posedge link_clk) begin
        scl_m <= scl_i;
        scl_s <= scl_m;
        scl_p <= scl_s;
        sda_m <= sda_i;
        sda_s <= sda_m;
        sda_p <= sda_s;
        ack_m <= cr.ack_tgl;
        ack_s <= ack_m;
        ack_p <= ack_s;
        abt_m <= cr.ctrl[CTRL_RST_BIT];
        abt_s <= abt_m;
        lrst_m <= reset;
        lrst_s <= lrst_m;
    end

    logic scl_rise, scl_fall, bus_start, bus_stop; // Bus events
    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
    assign bus_stop = scl_s & scl_p & ~sda_p & sda_s;

    // ****************************************************************
    // Serial byte engine
    // ****************************************************************
    // Next state of the serial engine
    always_comb begin
        logic [7:0] byte_in;
        byte_in = {lr.sh[6:0], sda_s};
        ln = lr;
        // Answer word is only taken once the toggle has settled
        if (ack_s ^ ack_p) begin
            ln.rdata = cr.rdata;
        end
        if (abt_s) begin
            ln.st = L_IDLE;
            ln.oe = 1'b0;
        end else if (bus_start) begin
            ln.st = L_ADDR;
            ln.cnt = 3'h0;
            ln.oe = 1'b0;
        end else if (bus_stop) begin
            ln.st = L_IDLE;
            ln.oe = 1'b0;
        end else begin
            case (lr.st)
                L_ADDR, L_REG, L_WDATA: begin
                    if (scl_rise) begin
                        ln.sh = byte_in;
                        ln.cnt = lr.cnt + 3'h1;
                        if (lr.cnt == 3'h7) begin
                            ln.st = L_ACK_W;
                            ln.after = L_WDATA;
                            if (lr.st == L_ADDR) begin
                                if (byte_in[7:1] != DEV_ADDR) begin
                                    ln.st = L_IDLE; // Not ours
                                end else if (byte_in[0]) begin
                                    ln.after = L_TX;
                                    ln.cmd = mk_cmd(1'b0, lr.ptr, 8'h00);
                                    ln.req_tgl = ~lr.req_tgl;
                                    ln.ptr = lr.ptr + 8'h01;
                                end else begin
                                    ln.after = L_REG;
                                end
                            end else if (lr.st == L_REG) begin
                                ln.ptr = byte_in;
                            end else begin
                                ln.cmd = mk_cmd(1'b1, lr.ptr, byte_in);
                                ln.req_tgl = ~lr.req_tgl;
                                ln.ptr = lr.ptr + 8'h01;
                            end
                        end
                    end
                end
                L_ACK_W: begin
                    if (scl_fall) begin
                        ln.oe = 1'b1; // Pull data low for ack
                        ln.st = L_ACK_H;
                    end
                end
                L_ACK_H, L_TX_LOAD: begin
                    if (scl_fall) begin
                        ln.cnt = 3'h0;
                        if (lr.st == L_TX_LOAD || lr.after == L_TX) begin
                            ln.sh = lr.rdata;
                            ln.oe = ~lr.rdata[7];
                            ln.st = L_TX;
                        end else begin
                            ln.oe = 1'b0;
                            ln.st = lr.after;
                        end
                    end
                end
                L_TX: begin
                    if (scl_rise) begin
                        ln.sh = {lr.sh[6:0], 1'b0};
                        ln.cnt = lr.cnt + 3'h1;
                        if (lr.cnt == 3'h7) begin
                            ln.st = L_MACK_W;
                        end
                    end else if (scl_fall) begin
                        ln.oe = ~lr.sh[7];
                    end
                end
                L_MACK_W: begin
                    if (scl_fall) begin
                        ln.oe = 1'b0; // Release for host ack
                        ln.st = L_MACK;
                    end
                end
                L_MACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            ln.cmd = mk_cmd(1'b0, lr.ptr, 8'h00);
                            ln.req_tgl = ~lr.req_tgl;
                            ln.ptr = lr.ptr + 8'h01;
                            ln.st = L_TX_LOAD;
                        end else begin
                            ln.st = L_IDLE; // Host ends the read
                        end
                    end
                end
                default: ln.st = L_IDLE;
            endcase
        end
    end

    // Serial state register
    always_ff @(posedge link_clk) begin
        if (lrst_s) begin
            lr <= '{st: L_IDLE, after: L_IDLE, default: '0};
            sda_o_r <= 1'b0;
        end else begin
            lr <= ln;
            sda_o_r <= 1'b0;
        end
    end

    assign sda_oe = lr.oe;
    assign sda_o = sda_o_r;

    // ****************************************************************
    // Register side
    // ****************************************************************
    logic req_m, req_s, req_p; // Request toggle, synchronised
    logic nvm_addr; // Reload read address
    logic [7:0] nvm_rdata; // Registered memory word

    // Request toggle crosses over two flops
    always_ff @(posedge ref_clk) begin
        req_m <= lr.req_tgl;
        req_s <= req_m;
        req_p <= req_s;
    end

    // Second memory word is read while the first lands
    assign nvm_addr = (cr.rc == 2'h2);

    osc_nvm #(
        .WORDS(NVM_WORDS),
        .W(8)
    ) u_nvm (
        .ref_clk(ref_clk),
        .addr(nvm_addr),
        .rdata(nvm_rdata)
    );

    // Next state of the registers and the oscillator controls
    always_comb begin
        cn = cr;
        if (cr.ctrl[CTRL_RST_BIT]) begin
            cn.clk_oe = 1'b0;
            cn.rst_cnt = cr.rst_cnt + 5'h1;
            if (cr.rst_cnt == 5'(INT_RST_CYCLES - 1)) begin
                cn.ctrl = CTRL_RST;
                cn.rst_cnt = 5'h0;
            end
        end else begin
            cn.clk_oe = 1'b1;
            // Frozen multiplier or loop keeps the word steady
            if (!cr.ctrl[CTRL_FRZM_BIT] && !cr.loop_frz) begin
                cn.freq_word = cr.refq;
            end
            if (!cr.ctrl[CTRL_FRZC_BIT]) begin
                cn.conv_word = conv_word_i;
            end
            // Settle time counts only while the loop runs
            if (cr.ctrl[CTRL_NF_BIT] && !cr.loop_frz) begin
                cn.nf_cnt = cr.nf_cnt + 5'h1;
                if (cr.nf_cnt == 5'(APPLY_CYCLES - 1)) begin
                    cn.ctrl[CTRL_NF_BIT] = 1'b0;
                    cn.nf_cnt = 5'h0;
                end
            end else begin
                cn.nf_cnt = 5'h0;
            end
            // Reload walks the memory; serial side untouched
            case (cr.rc)
                2'h0: begin
                    if (cr.ctrl[CTRL_RECALL_BIT]) begin
                        cn.rc = 2'h1;
                    end
                end
                2'h1: cn.rc = 2'h2;
                2'h2: begin
                    cn.refq = nvm_rdata;
                    cn.rc = 2'h3;
                end
                default: begin
                    cn.loop_frz = nvm_rdata[LOOP_FRZ_BIT];
                    cn.ctrl[CTRL_RECALL_BIT] = 1'b0;
                    cn.rc = 2'h0;
                end
            endcase
        end
        // Host access comes last so a host set beats a self clear
        if (req_s ^ req_p) begin
            cn.rdata = read_img(cr, lr.cmd.addr);
            cn.ack_tgl = ~cr.ack_tgl;
            if (lr.cmd.wr && !cr.ctrl[CTRL_RST_BIT]) begin
                case (lr.cmd.addr)
                    REFQ_LOW_OFS: cn.refq = lr.cmd.data;
                    CTRL_OFS: begin
                        if (lr.cmd.data[CTRL_RST_BIT]) begin
                            // Whole block restarts, clock off
                            cn.ctrl = 8'h80;
                            cn.refq = REFQ_LOW_RST;
                            cn.loop_frz = LOOP_RST;
                            cn.rc = 2'h0;
                            cn.nf_cnt = 5'h0;
                            cn.rst_cnt = 5'h0;
                        end else begin
                            cn.ctrl[CTRL_NF_BIT] =
                                lr.cmd.data[CTRL_NF_BIT];
                            cn.ctrl[CTRL_FRZM_BIT] =
                                lr.cmd.data[CTRL_FRZM_BIT];
                            cn.ctrl[CTRL_FRZC_BIT] =
                                lr.cmd.data[CTRL_FRZC_BIT];
                            cn.ctrl[CTRL_RECALL_BIT] =
                                cn.ctrl[CTRL_RECALL_BIT] |
                                lr.cmd.data[CTRL_RECALL_BIT];
                        end
                    end
                    LOOP_OFS: cn.loop_frz =
                        lr.cmd.data[LOOP_FRZ_BIT];
                    default: cn.refq = cr.refq; // Unmapped; refq held, dropping a reload copy landing this cycle
                endcase
            end
        end
    end

    // Register side state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cr <= '0;
        end else begin
            cr <= cn;
        end
    end

    assign freq_word = cr.freq_word;
    assign conv_word = cr.conv_word;
    assign loop_frozen = cr.loop_frz;
    assign clk_out_oe = cr.clk_oe;

    // ****************************************************************
    // Checks
    // ****************************************************************
    rst_self_clear_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(cr.ctrl[CTRL_RST_BIT]) |-> ##[1:25] !cr.ctrl[CTRL_RST_BIT])
        else $error("internal reset bit did not clear");
    clk_tristate_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        cr.ctrl[CTRL_RST_BIT] |=> !clk_out_oe)
        else $error("clock output driven during internal reset");
    mult_freeze_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (cr.ctrl[CTRL_FRZM_BIT] && !cr.ctrl[CTRL_RST_BIT])
        ##1 !cr.ctrl[CTRL_RST_BIT] |-> $stable(freq_word))
        else $error("frequency word moved while frozen");
    conv_freeze_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (cr.ctrl[CTRL_FRZC_BIT] && !cr.ctrl[CTRL_RST_BIT])
        |=> $stable(conv_word))
        else $error("converter word moved while frozen");
    recall_done_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(cr.ctrl[CTRL_RECALL_BIT]) && !cr.ctrl[CTRL_RST_BIT]
        |-> ##[1:6] (!cr.ctrl[CTRL_RECALL_BIT] && cr.refq == NVM_REFQ_INIT))
        else $error("reload did not complete");
    new_frequency_handshake_clear_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(cr.ctrl[CTRL_NF_BIT]) && !cr.loop_frz
        |-> ##[1:14] (!cr.ctrl[CTRL_NF_BIT] || cr.loop_frz))
        else $error("new frequency bit did not clear");
    loop_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        cr.loop_frz ##1 cr.loop_frz |-> $stable(freq_word))
        else $error("frequency word moved while loop frozen");
    ctrl_reset_a: assert property (
        @(posedge ref_clk) $fell(reset) |-> read_img(cr, CTRL_OFS) == 8'h00)
        else $error("control register not zero after reset");
    link_abort_a: assert property (
        @(posedge link_clk) disable iff (lrst_s)
        abt_s |=> (lr.st == L_IDLE && !sda_oe))
        else $error("serial engine not aborted by internal reset");

endmodule : osc_ctrl

//--- bench/osc_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Serial host model: open drain, never stretches, idles released
// ****************************************************************
module osc_host #(
    parameter int Q = 260 // Quarter bit; 2*Q spans eight link periods
) (
    output logic scl,
    output logic sda_low, // High pulls the data wire low
    input wire logic sda
);
    // Both wires released while no frame runs
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One bit; data moves mid-low so the synced clock never sees it
    task automatic bit_x(input logic b, output logic r);
        #(Q) sda_low = !b;
        #(Q) scl = 1'b1;
        #(2*Q) r = sda;
        scl = 1'b0;
    endtask : bit_x

    // Start or repeated start: data falls while clock is high
    task automatic start_c();
        #(Q) sda_low = 1'b0;
        #(Q) scl = 1'b1;
        #(Q) sda_low = 1'b1;
        #(Q) scl = 1'b0;
    endtask : start_c

    // Stop: data rises while clock is high, then bus idles
    task automatic stop_c();
        #(Q) sda_low = 1'b1;
        #(Q) scl = 1'b1;
        #(Q) sda_low = 1'b0;
        #(Q);
    endtask : stop_c

    // Byte out, most significant bit first, then the device's ack
    task automatic put(input logic [7:0] b, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r);
        bit_x(1'b1, r);
        ok = ok & !r;
    endtask : put

    // Register write; ok only if every byte was acknowledged
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, d,
                      output logic ok);
        ok = 1'b1;
        start_c();
        put({dev, 1'b0}, ok);
        if (ok) begin
            put(a, ok);
            put(d, ok);
        end
        stop_c();
    endtask : wr

    // Two byte read: host acks the first, refuses the second to end it
    task automatic rd(input logic [6:0] dev, input logic [7:0] a,
                      output logic [7:0] d, d2);
        logic ok, r;
        ok = 1'b1;
        start_c();
        put({dev, 1'b0}, ok);
        put(a, ok);
        start_c();
        put({dev, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(1'b0, r); // Ack asks for the byte at the next offset
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d2[i]);
        bit_x(1'b1, r);
        stop_c();
        if (!ok) begin
            d = 8'hxx; // Unanswered read never matches
            d2 = 8'hxx;
        end
    endtask : rd
endmodule : osc_host

//--- bench/osc_ctrl_tb.sv
`timescale 1ns/1ps
module osc_ctrl_tb
    import osc_pkg::*;
();
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [6:0] DEV = 7'h55; // Arbitrary bus address
    logic ref_clk, link_clk, reset, scl, host_low;
    logic sda_o, sda_oe, clk_out_oe, loop_frozen, ok, saw_off;
    logic [7:0] freq_word, rd_d, rd_d2, r1, r2, obs, e_w;
    logic [CONV_W-1:0] conv_in, conv_word, c1;
    logic [31:0] seed = 32'he48daec4; // Fixed start, repeatable run
    logic [7:0] exp_q[$]; // Expected values, oldest first
    event obs_ev;
    int err_total = 0;
    int cmp_count = 0;
    // Pulled up unless a party pulls it low
    wire sda_w = !(host_low | (sda_oe & !sda_o));

    // Fast register clock and free link clock, phases unrelated
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = !ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #32 link_clk = !link_clk;
    end

    osc_ctrl #(.DEV_ADDR(DEV)) dut (.ref_clk(ref_clk), .reset(reset),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .conv_word_i(conv_in), .freq_word(freq_word),
        .conv_word(conv_word), .loop_frozen(loop_frozen),
        .clk_out_oe(clk_out_oe));
    osc_host host (.scl(scl), .sda_low(host_low), .sda(sda_w));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd

    // Note the expectation, then show the observed value
    task automatic chk(input logic [7:0] e, o);
        exp_q.push_back(e);
        obs = o;
        ->obs_ev;
        #1;
    endtask : chk

    // Host frames start 1 ns after a register clock edge
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        #1;
        host.wr(DEV, a, d, ok);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        #1;
        host.rd(DEV, a, rd_d, rd_d2);
    endtask : rd
    task automatic settle();
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    // Compare each shown value with the oldest expectation
    initial forever begin
        @(obs_ev);
        e_w = exp_q.pop_front();
        cmp_count++;
        if (e_w !== obs) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, obs, e_w);
        end
    end

    // Remember any gap in the clock output enable
    always @(posedge ref_clk) begin
        if (!reset && clk_out_oe === 1'b0) saw_off <= 1'b1;
    end

    // Hang guard, about a tenth beyond the expected run of 453 us
    initial begin
        #495000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        results();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        reset = 1'b1;
        conv_in = 8'h00;
        saw_off = 1'b0;
        // Long enough for the link side copy of reset as well
        repeat (5) @(posedge link_clk);
        @(posedge ref_clk);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge link_clk);
        // Wrong address must be ignored, internal reset not taken
        @(posedge ref_clk);
        #1;
        host.wr(DEV ^ 7'h01, CTRL_OFS, 8'h80, ok);
        chk(8'h00, {7'h0, ok});
        rd(CTRL_OFS);
        chk(CTRL_RST & 8'hcf, rd_d & 8'hcf);
        chk(8'h01, {7'h0, clk_out_oe});
        $display("test reset_state done");

        // Word follows the byte, then both freezes hold their words
        r1 = rnd();
        r2 = ~r1;
        c1 = rnd();
        // Same-clock input changes just after an edge
        @(posedge ref_clk);
        #1;
        conv_in = c1;
        wr(REFQ_LOW_OFS, r1);
        chk(r1, freq_word);
        wr(CTRL_OFS, 8'h30);
        @(posedge ref_clk);
        #1;
        conv_in = ~c1;
        wr(REFQ_LOW_OFS, r2);
        chk(r1, freq_word);
        chk(c1, conv_word);
        rd(REFQ_LOW_OFS);
        chk(r2, rd_d);
        // Pointer steps on to an unmapped offset, which reads zero
        chk(8'h00, rd_d2);
        wr(CTRL_OFS, 8'h40);
        settle();
        chk(r2, freq_word);
        chk(~c1, conv_word);
        $display("test freeze_word done");

        // Loop freeze, then a reload with a new frequency pending
        wr(LOOP_OFS, 8'h10);
        chk(8'h01, {7'h0, loop_frozen});
        wr(REFQ_LOW_OFS, r1);
        chk(r2, freq_word);
        wr(CTRL_OFS, 8'h41);
        chk(8'h01, {7'h0, ok});
        settle();
        chk(NVM_REFQ_INIT, freq_word);
        chk({7'h0, NVM_LOOP_INIT[LOOP_FRZ_BIT]}, {7'h0, loop_frozen});
        rd(CTRL_OFS);
        chk(8'h00, rd_d);
        $display("test reload done");

        // Internal reset: output off for a while, then self-clear
        saw_off = 1'b0;
        wr(CTRL_OFS, 8'h80);
        chk(8'h01, {7'h0, saw_off});
        chk(8'h01, {7'h0, clk_out_oe});
        chk(8'h00, freq_word);
        rd(CTRL_OFS);
        chk(8'h00, rd_d);
        $display("test internal_reset done");
        results();
    end
endmodule : osc_ctrl_tb
